// [logic/rcs_top.sv]
// Receiver control section: display scan, remote latches, handshake, channel store, synth feed.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Three groups, six digits, eight segments each.
// R2: Normal digit lit 2 ms per 16 ms.
// R3: Intensified digit lit 6 ms per frame.
// R4: Parallel latch only on select code match.
// R5: Parallel latching paced by bus alone.
// R6: Controller reads latches on own timing.
// R7: IEEE handshake runs without stalling controller.
// R8: IEEE values held in readable ports.
// R9: Store holds up to 100 channels.
// R10: Save state on power loss, restore after.
// R11: Write store only when contents differ.
// R12: Serial synth data plus parallel control outputs.
// R13: Keypad and knob sampled through input ports.
// R14: Synth shift register takes serial word.
// R15: Fixed repeating 2 ms slot scan order.
module rcs_top #(
  parameter int SLOT_CYCLES = rcs_pkg::SLOT_CYC_DEF  // Cycles per display slot.
) (
  // Clock and reset.
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // Display contents and intensification.
  input wire logic [rcs_pkg::DISP_BITS-1:0] disp_data_in,
  input wire logic intens_en_in,
  input wire logic [1:0] intens_grp_in,
  input wire logic [2:0] intens_pos_in,
  // Display drive.
  output logic [5:0] dig_sel_out,
  output logic [23:0] seg_out,
  // Parallel remote bus.
  input wire logic par_stb_in,
  input wire logic [4:0] par_sel_in,
  input wire logic [1:0] par_addr_in,
  input wire logic [7:0] par_data_in,
  input wire logic [4:0] jumper_sel_in,
  // IEEE-488 acceptor lines, low true.
  input wire logic dav_b_in,
  input wire logic atn_b_in,
  input wire logic [7:0] dio_b_in,
  output logic nrfd_o_out,
  output logic nrfd_oe_out,
  output logic ndac_o_out,
  output logic ndac_oe_out,
  // Remote selection.
  input wire logic remote_en_in,
  input wire logic remote_src_in,
  // Panel inputs.
  input wire logic key_valid_in,
  input wire logic [3:0] key_code_in,
  input wire logic knob_up_in,
  input wire logic knob_dn_in,
  input wire logic pwr_fail_in,
  // Synthesizer serial feed and module controls.
  output logic syn_clk_out,
  output logic syn_data_out,
  output logic syn_load_out,
  output logic [7:0] ctl_out,
  // Status.
  output logic [23:0] freq_out,
  output logic [6:0] chan_out,
  output logic ready_out
);
  import rcs_pkg::*;

  rcs_state_type s_reg;     // Whole state of the block.
  rcs_state_type s_next;    // Next value of the state.
  logic [31:0] mem_rdata;   // Registered read data from the store.
  logic [23:0] seg_mux;     // Segment pattern chosen for the current slot.
  logic spare_slot;         // Slot past the six digit positions.
  logic par_hit;            // Parallel strobe edge with matching select code.

  assign spare_slot = (s_reg.slot >= 3'(DIGITS));
  assign par_hit = par_stb_in && !s_reg.par_prev && (par_sel_in == jumper_sel_in);

  // ****************************************************************
  // Channel store
  // ****************************************************************
  rcs_channel_mem u_mem (
    .mclk_in(mclk_in),
    .re_in(s_reg.mem_re),
    .we_in(s_reg.mem_we),
    .addr_in(s_reg.mem_addr),
    .wdata_in(s_reg.mem_wdata),
    .rdata_out(mem_rdata)
  );

  // ****************************************************************
  // Segment selection, one slice per display group
  // ****************************************************************
  // In a spare slot only the intensified group lights, so one digit gains the time.
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
      assign seg_mux[g*SEGS +: SEGS] = !spare_slot ?
          disp_data_in[(g*DIGITS + int'(s_reg.slot))*SEGS +: SEGS] :  // [R1]
          (intens_en_in && intens_grp_in == 2'(g) && intens_pos_in < 3'(DIGITS)) ?
          disp_data_in[(g*DIGITS + int'(intens_pos_in))*SEGS +: SEGS] : 8'h00;  // [R3]
    end
  endgenerate

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.mem_re = 1'b0;
    s_next.mem_we = 1'b0;
    s_next.ser_load = 1'b0;

    // Display scan: fixed slot order, six digit slots then spare slots.
    if (s_reg.slot_cnt == 20'(SLOT_CYCLES - 1)) begin
      s_next.slot_cnt = 20'h00000;
      s_next.slot = (s_reg.slot == 3'(SLOTS_PER_FRAME - 1)) ? 3'h0 : s_reg.slot + 3'h1;  // [R15]
    end else begin
      s_next.slot_cnt = s_reg.slot_cnt + 20'h00001;  // [R2]
    end
    if (!spare_slot) begin
      s_next.dig = 6'h01 << s_reg.slot;  // [R1] [R2]
    end else if (intens_en_in && intens_pos_in < 3'(DIGITS)) begin
      s_next.dig = 6'h01 << intens_pos_in;  // [R3]
    end else begin
      s_next.dig = 6'h00;
    end
    s_next.seg = seg_mux;

    // Remote poll timer and power-fail edge; a pending save waits for the controller.
    s_next.poll = (s_reg.poll == 12'(POLL_CYC - 1)) ? 12'h000 : s_reg.poll + 12'h001;
    s_next.pf_prev = pwr_fail_in;

    // Serial feed: a word leaves MSB first, then a one-cycle load strobe.
    if (s_reg.ser_busy) begin
      if (s_reg.ser_div == 3'(SER_HALF_CYC - 1)) begin
        s_next.ser_div = 3'h0;
        if (!s_reg.ser_clk) begin
          s_next.ser_clk = 1'b1;  // [R14]
        end else begin
          s_next.ser_clk = 1'b0;
          if (s_reg.ser_bit == 6'(SER_BITS - 1)) begin
            s_next.ser_busy = 1'b0;
            s_next.ser_load = 1'b1;  // [R12]
          end else begin
            s_next.ser_bit = s_reg.ser_bit + 6'h01;
            s_next.ser_sr = {s_reg.ser_sr[30:0], 1'b0};
          end
        end
      end else begin
        s_next.ser_div = s_reg.ser_div + 3'h1;
      end
    end else if (s_reg.ser_pend) begin
      s_next.ser_busy = 1'b1;
      s_next.ser_pend = 1'b0;
      s_next.ser_bit = 6'h00;
      s_next.ser_div = 3'h0;
      s_next.ser_sr = {s_reg.freq, s_reg.setg};  // [R12]
    end

    // Central controller.
    unique case (s_reg.ctl)
      CS_BOOT: begin
        s_next.mem_re = 1'b1;
        s_next.mem_addr = SAVE_ADDR;  // [R10]
        s_next.ctl = CS_BOOT_WAIT;
      end
      CS_BOOT_WAIT, CS_RCL_WAIT: begin
        // The store answers one cycle after its registered read strobe.
        s_next.ctl = (s_reg.ctl == CS_BOOT_WAIT) ? CS_BOOT_LOAD : CS_RCL_LOAD;
      end
      CS_BOOT_LOAD, CS_RCL_LOAD: begin
        // At boot a blank or corrupt word falls back to a safe default tuning; on recall it leaves the current tuning.
        if (mem_rdata[31:8] <= FREQ_MAX && mem_rdata[31:8] >= FREQ_MIN) begin
          s_next.freq = mem_rdata[31:8];  // [R10]
          s_next.setg = mem_rdata[7:0];
        end else if (s_reg.ctl == CS_BOOT_LOAD) begin
          s_next.freq = FREQ_DEF;
          s_next.setg = 8'h00;
        end
        s_next.ser_pend = 1'b1;
        s_next.ready = 1'b1;
        s_next.ctl = CS_RUN;
      end
      CS_RUN: begin
        if (s_reg.pf_pend) begin
          s_next.pf_pend = 1'b0;
          s_next.mem_re = 1'b1;
          s_next.mem_addr = SAVE_ADDR;  // [R10]
          s_next.ctl = CS_SAVE_WAIT;
        end else if (key_valid_in && key_code_in == KEY_STORE) begin
          s_next.mem_re = 1'b1;
          s_next.mem_addr = s_reg.chan;  // [R9]
          s_next.ctl = CS_SAVE_WAIT;
        end else if (key_valid_in && key_code_in == KEY_RECALL) begin
          s_next.mem_re = 1'b1;
          s_next.mem_addr = s_reg.chan;  // [R9]
          s_next.ctl = CS_RCL_WAIT;
        end else if (key_valid_in && key_code_in < KEY_DIGITS) begin
          // Two-digit decimal entry keeps the channel number below one hundred.
          s_next.chan = 7'((s_reg.chan % CHAN_RADIX) * CHAN_RADIX) + {3'h0, key_code_in};  // [R13]
        end else if (s_reg.poll == 12'h000 && remote_en_in && !remote_src_in && s_reg.par_new) begin
          s_next.freq = s_reg.par_lat[31:8];  // [R6]
          s_next.setg = s_reg.par_lat[7:0];
          s_next.par_new = 1'b0;
          s_next.ser_pend = 1'b1;
        end else if (s_reg.poll == 12'h000 && remote_en_in && remote_src_in && s_reg.ieee_new) begin
          s_next.freq = s_reg.ieee_lat[31:8];  // [R8]
          s_next.setg = s_reg.ieee_lat[7:0];
          s_next.ieee_new = 1'b0;
          s_next.ser_pend = 1'b1;
        end else if (knob_up_in && s_reg.freq < FREQ_MAX) begin
          s_next.freq = s_reg.freq + FREQ_STEP;  // [R13]
          s_next.ser_pend = 1'b1;
        end else if (knob_dn_in && s_reg.freq > FREQ_MIN) begin
          s_next.freq = s_reg.freq - FREQ_STEP;  // [R13]
          s_next.ser_pend = 1'b1;
        end
      end
      CS_SAVE_WAIT: begin
        s_next.ctl = CS_SAVE_CMP;
      end
      CS_SAVE_CMP: begin
        // Each write wears the part, so an unchanged word is not rewritten.
        // A word that reads back unknown counts as changed and is written.
        if (mem_rdata == {s_reg.freq, s_reg.setg}) begin
          s_next.mem_we = 1'b0;  // [R11]
        end else begin
          s_next.mem_we = 1'b1;  // [R11]
          s_next.mem_wdata = {s_reg.freq, s_reg.setg};
        end
        s_next.ctl = CS_RUN;
      end
    endcase
    if (pwr_fail_in && !s_reg.pf_prev) begin
      s_next.pf_pend = 1'b1;
    end
    s_next.ctl_o = s_reg.setg;  // [R12]

    // Parallel latches: set here, after the controller, so a capture beats a clear.
    s_next.par_prev = par_stb_in;
    if (par_hit) begin
      s_next.par_lat[(3 - int'(par_addr_in))*8 +: 8] = par_data_in;  // [R4] [R5]
      s_next.par_new = 1'b1;
    end

    // IEEE-488 acceptor handshake, independent of the controller state.
    unique case (s_reg.ah)
      AH_IDLE: begin
        s_next.nrfd_oe = 1'b0;
        s_next.ndac_oe = 1'b1;
        s_next.ah = AH_READY;
      end
      AH_READY: begin
        if (!dav_b_in) begin
          if (!atn_b_in) begin
            s_next.ieee_ptr = ~dio_b_in[1:0];
          end else begin
            s_next.ieee_lat[(3 - int'(s_reg.ieee_ptr))*8 +: 8] = ~dio_b_in;  // [R8]
            s_next.ieee_ptr = s_reg.ieee_ptr + 2'h1;
            s_next.ieee_new = 1'b1;
          end
          s_next.nrfd_oe = 1'b1;  // [R7]
          s_next.ndac_oe = 1'b0;
          s_next.ah = AH_ACCEPT;
        end
      end
      AH_ACCEPT: begin
        if (dav_b_in) begin
          s_next.ndac_oe = 1'b1;  // [R7]
          s_next.nrfd_oe = 1'b0;
          s_next.ah = AH_READY;
        end
      end
      default: begin
        s_next.ah = AH_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register; open-drain lines only pull low.
  assign dig_sel_out = s_reg.dig;
  assign seg_out = s_reg.seg;
  assign nrfd_o_out = s_reg.par_prev & 1'b0;
  assign nrfd_oe_out = s_reg.nrfd_oe;
  assign ndac_o_out = s_reg.par_prev & 1'b0;
  assign ndac_oe_out = s_reg.ndac_oe;
  assign syn_clk_out = s_reg.ser_clk;
  assign syn_data_out = s_reg.ser_sr[31];
  assign syn_load_out = s_reg.ser_load;
  assign ctl_out = s_reg.ctl_o;
  assign freq_out = s_reg.freq;
  assign chan_out = s_reg.chan;
  assign ready_out = s_reg.ready;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  property p_dig_onehot;
    $onehot0(dig_sel_out);
  endproperty
  a_dig_onehot: assert property (p_dig_onehot) else $error("digit select not one-hot"); // [R1]

  property p_slot_step;
    $changed(s_reg.slot) |-> $past(s_reg.slot_cnt) == 20'(SLOT_CYCLES - 1);
  endproperty
  a_slot_step: assert property (p_slot_step) else $error("slot advanced early"); // [R2] [R15]

  property p_intens;
    (spare_slot && intens_en_in && intens_pos_in < 3'(DIGITS))
        |=> dig_sel_out == (6'h01 << $past(intens_pos_in));
  endproperty
  a_intens: assert property (p_intens) else $error("spare slot not given to bright digit"); // [R3]

  property p_par_match;
    $changed(s_reg.par_lat) |-> $past(par_sel_in == jumper_sel_in);
  endproperty
  a_par_match: assert property (p_par_match) else $error("latch changed without match"); // [R4]

  property p_par_capture;
    par_hit |=> s_reg.par_new && s_reg.par_lat[(3 - int'($past(par_addr_in)))*8 +: 8]
        == $past(par_data_in);
  endproperty
  a_par_capture: assert property (p_par_capture) else $error("bus write not captured"); // [R5]

  property p_ah_accept;
    (s_reg.ah == AH_READY && !dav_b_in) |=> nrfd_oe_out && !ndac_oe_out;
  endproperty
  a_ah_accept: assert property (p_ah_accept) else $error("handshake did not accept"); // [R7]

  property p_mem_differs;
    (s_reg.ctl == CS_SAVE_CMP && mem_rdata == {s_reg.freq, s_reg.setg}) |=> !s_reg.mem_we;
  endproperty
  a_mem_differs: assert property (p_mem_differs) else $error("redundant store write"); // [R11]

  property p_load_pulse;
    syn_load_out |-> $past(s_reg.ser_busy) ##1 !syn_load_out;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load strobe malformed"); // [R14]

  property p_boot_ready;
    $rose(ready_out) |-> $past(s_reg.ctl) == CS_BOOT_LOAD && s_reg.ser_pend;
  endproperty
  a_boot_ready: assert property (p_boot_ready) else $error("restore skipped"); // [R10]

  c_intens: cover property (spare_slot && intens_en_in && dig_sel_out != 6'h00);
  c_save: cover property (s_reg.ctl == CS_SAVE_CMP && s_next.mem_we);
  c_ieee: cover property (s_reg.ah == AH_ACCEPT ##1 s_reg.ah == AH_READY);
  c_load: cover property (syn_load_out);

endmodule : rcs_top

// [logic/rcs_pkg.sv]
// Shared constants, encodings and the state record of the receiver control section.
package rcs_pkg;

  // ****************************************************************
  // Clock and display timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;          // Core clock rate in MHz.
  localparam int SLOT_MS = 2;            // Normal on-time of one digit, in ms.
  localparam int FRAME_MS = 16;          // Refresh frame length, in ms.
  localparam int INTENS_MS = 6;          // On-time of the intensified digit, in ms.
  localparam int SLOT_CYC_DEF = SLOT_MS * CLK_MHZ * 1000;  // Cycles per slot.
  localparam int SLOTS_PER_FRAME = FRAME_MS / SLOT_MS;     // Slots in one frame.
  localparam int INTENS_SLOTS = INTENS_MS / SLOT_MS;       // Slots the bright digit gets.
  localparam int NUM_GROUPS = 3;         // Display groups.
  localparam int DIGITS = 6;             // Digits per group.
  localparam int SEGS = 8;               // Segments per digit.
  localparam int DISP_BITS = NUM_GROUPS * DIGITS * SEGS;

  // ****************************************************************
  // Controller timing and tuning limits
  // ****************************************************************
  localparam int POLL_US = 10;                          // Remote poll interval, in us.
  localparam int POLL_CYC = POLL_US * CLK_MHZ;          // Cycles per poll.
  localparam int SER_HALF_NS = 20;                      // Serial clock half period, in ns.
  localparam int SER_HALF_CYC = SER_HALF_NS * CLK_MHZ / 1000;
  localparam int SER_BITS = 32;                         // Bits per synthesizer word.
  localparam logic [23:0] FREQ_MAX = 24'h2dc6c0;        // 30 MHz in 10 Hz steps.
  localparam logic [23:0] FREQ_MIN = 24'h0001f4;        // 5 kHz in 10 Hz steps.
  localparam logic [23:0] FREQ_DEF = 24'h0f4240;        // 10 MHz, used on a blank store.
  localparam logic [23:0] FREQ_STEP = 24'h000001;       // One knob detent.

  // ****************************************************************
  // Channel store and keypad codes
  // ****************************************************************
  localparam int NUM_CHANNELS = 100;                    // Stored channels.
  localparam int MEM_DEPTH = NUM_CHANNELS + 1;          // Plus the last-state slot.
  localparam logic [6:0] SAVE_ADDR = 7'h64;             // Last-state slot address.
  localparam logic [3:0] KEY_STORE = 4'ha;              // Key code: store channel.
  localparam logic [3:0] KEY_RECALL = 4'hb;             // Key code: recall channel.
  localparam logic [3:0] KEY_DIGITS = 4'ha;             // Codes below this are digits.
  localparam logic [6:0] CHAN_RADIX = 7'h0a;            // Decimal channel entry.

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    AH_IDLE = 2'b00,
    AH_READY = 2'b01,
    AH_ACCEPT = 2'b10
  } rcs_ah_state_type;

  typedef enum logic [2:0] {
    CS_BOOT = 3'b000,
    CS_BOOT_WAIT = 3'b001,
    CS_BOOT_LOAD = 3'b010,
    CS_RUN = 3'b011,
    CS_SAVE_WAIT = 3'b100,
    CS_SAVE_CMP = 3'b101,
    CS_RCL_WAIT = 3'b110,
    CS_RCL_LOAD = 3'b111
  } rcs_ctl_state_type;

  typedef struct packed {
    logic [19:0] slot_cnt;
    logic [2:0] slot;
    logic [5:0] dig;
    logic [23:0] seg;
    logic par_prev;
    logic [31:0] par_lat;
    logic par_new;
    rcs_ah_state_type ah;
    logic nrfd_oe;
    logic ndac_oe;
    logic [1:0] ieee_ptr;
    logic [31:0] ieee_lat;
    logic ieee_new;
    rcs_ctl_state_type ctl;
    logic [23:0] freq;
    logic [7:0] setg;
    logic [6:0] chan;
    logic [11:0] poll;
    logic pf_prev;
    logic pf_pend;
    logic ready;
    logic mem_re;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [31:0] mem_wdata;
    logic ser_pend;
    logic ser_busy;
    logic ser_clk;
    logic ser_load;
    logic [5:0] ser_bit;
    logic [2:0] ser_div;
    logic [31:0] ser_sr;
    logic [7:0] ctl_o;
  } rcs_state_type;

endpackage : rcs_pkg

// [logic/rcs_channel_mem.sv]
// Channel and last-state store with a registered read port.
`timescale 1ns/1ps
module rcs_channel_mem (
  // Clock.
  input wire logic mclk_in,
  // Access port.
  input wire logic re_in,
  input wire logic we_in,
  input wire logic [6:0] addr_in,
  input wire logic [31:0] wdata_in,
  // Read data, valid the cycle after re_in.
  output logic [31:0] rdata_out
);
  import rcs_pkg::*;

  // Storage stands for the non-volatile parts, so it has no reset.
  logic [31:0] mem [MEM_DEPTH];

  // ****************************************************************
  // Single port: a write and a read are never issued together.
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    if (re_in) begin
      rdata_out <= mem[addr_in];
    end
  end

endmodule : rcs_channel_mem

// [test/rcs_remote_model.sv]
// Behavioural remote controller that drives the parallel and IEEE-488 buses.
`timescale 1ns/1ps
module rcs_remote_model (
  // Clock.
  input wire logic mclk_in,
  // Acceptor line enables from the receiver.
  input wire logic nrfd_oe_in,
  input wire logic ndac_oe_in,
  // Parallel bus drive.
  output logic par_stb_out,
  output logic [4:0] par_sel_out,
  output logic [1:0] par_addr_out,
  output logic [7:0] par_data_out,
  // IEEE-488 talker drive, low true.
  output logic dav_b_out,
  output logic atn_b_out,
  output logic [7:0] dio_b_out
);
  int n;  // Bounded wait counter.

  // ****************************************************************
  // Idle bus levels
  // ****************************************************************
  // The IEEE lines are pulled up, so released lines read high.
  initial begin
    par_stb_out = 1'b0;
    par_sel_out = 5'h00;
    par_addr_out = 2'h0;
    par_data_out = 8'h00;
    dav_b_out = 1'b1;
    atn_b_out = 1'b1;
    dio_b_out = 8'hff;
  end

  // Sends one word, top byte to latch 0; the strobe drops for two cycles between bytes.
  task automatic par_word(input logic [4:0] sel, input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      @(negedge mclk_in);
      par_sel_out = sel;
      par_addr_out = 2'(i);
      par_data_out = w[31 - 8 * i -: 8];
      par_stb_out = 1'b1;
      @(negedge mclk_in);
      par_stb_out = 1'b0;
      @(negedge mclk_in);
      par_data_out = ~par_data_out;  // Released data no longer shows the old byte.
    end
  endtask : par_word

  // One three-wire handshake; the waits are bounded so a dead acceptor cannot hang us.
  task automatic ieee_byte(input logic atn_b, input logic [7:0] b);
    @(negedge mclk_in);
    for (n = 0; n < 200 && (nrfd_oe_in !== 1'b0 || ndac_oe_in !== 1'b1); n++) @(negedge mclk_in);
    dio_b_out = ~b;
    atn_b_out = atn_b;
    @(negedge mclk_in);
    dav_b_out = 1'b0;
    for (n = 0; n < 200 && ndac_oe_in !== 1'b0; n++) @(negedge mclk_in);
    dav_b_out = 1'b1;
    @(negedge mclk_in);
    dio_b_out = 8'hff;
    atn_b_out = 1'b1;
  endtask : ieee_byte
endmodule : rcs_remote_model

// [test/tb_top.sv]
// Self-checking bench of the receiver control section.
`timescale 1ns/1ps
module tb_top;
  import rcs_pkg::*;
  localparam int SC = 8;  // Short slot keeps a display frame at 64 cycles.
  logic mclk_in, rst_b_in, intens_en_in, dav_b_in, atn_b_in, par_stb_in;
  logic remote_en_in, remote_src_in, key_valid_in, knob_up_in, knob_dn_in, pwr_fail_in;
  logic [DISP_BITS-1:0] disp_data_in;
  logic [1:0] intens_grp_in, par_addr_in;
  logic [2:0] intens_pos_in;
  logic [4:0] par_sel_in, jumper_sel_in;
  logic [7:0] par_data_in, dio_b_in, ctl_out, s;
  logic [3:0] key_code_in;
  logic [5:0] dig_sel_out;
  logic [23:0] seg_out, freq_out, f;
  logic [31:0] w, sw;
  logic [6:0] chan_out;
  logic nrfd_o_out, nrfd_oe_out, ndac_o_out, ndac_oe_out, syn_clk_out, syn_data_out;
  logic syn_load_out, ready_out, count_on, clk_prev;
  int fails, cmp_count, cyc, n, bits, loads, on_cnt [18];
  integer seed;

  rcs_top #(.SLOT_CYCLES(SC)) dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .disp_data_in(disp_data_in),
    .intens_en_in(intens_en_in), .intens_grp_in(intens_grp_in), .intens_pos_in(intens_pos_in),
    .dig_sel_out(dig_sel_out), .seg_out(seg_out), .par_stb_in(par_stb_in),
    .par_sel_in(par_sel_in), .par_addr_in(par_addr_in), .par_data_in(par_data_in),
    .jumper_sel_in(jumper_sel_in), .dav_b_in(dav_b_in), .atn_b_in(atn_b_in),
    .dio_b_in(dio_b_in), .nrfd_o_out(nrfd_o_out), .nrfd_oe_out(nrfd_oe_out),
    .ndac_o_out(ndac_o_out), .ndac_oe_out(ndac_oe_out), .remote_en_in(remote_en_in),
    .remote_src_in(remote_src_in), .key_valid_in(key_valid_in), .key_code_in(key_code_in),
    .knob_up_in(knob_up_in), .knob_dn_in(knob_dn_in), .pwr_fail_in(pwr_fail_in),
    .syn_clk_out(syn_clk_out), .syn_data_out(syn_data_out), .syn_load_out(syn_load_out),
    .ctl_out(ctl_out), .freq_out(freq_out), .chan_out(chan_out), .ready_out(ready_out));

  rcs_remote_model rc (
    .mclk_in(mclk_in), .nrfd_oe_in(nrfd_oe_out), .ndac_oe_in(ndac_oe_out),
    .par_stb_out(par_stb_in), .par_sel_out(par_sel_in), .par_addr_out(par_addr_in),
    .par_data_out(par_data_in), .dav_b_out(dav_b_in), .atn_b_out(atn_b_in),
    .dio_b_out(dio_b_in));

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      $display("wrong value at %0t: %s", $time, msg);
      fails++;
    end
  endtask : chk

  task automatic results();
    $display("checks %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // A normal digit owns one slot of eight; the bright one gets two spare slots more.
  function automatic int exp_on(int k);
    return (intens_en_in === 1'b1 && k == 6 * int'(intens_grp_in) + int'(intens_pos_in)) ?
        3 * SC : SC;
  endfunction : exp_on

  task automatic key(input logic [3:0] c);
    @(negedge mclk_in);
    key_valid_in = 1'b1;
    key_code_in = c;
    @(negedge mclk_in);
    key_valid_in = 1'b0;
    repeat (6) @(negedge mclk_in);
  endtask : key

  // Holds a knob line for a number of cycles, one step per cycle.
  task automatic knob(input logic up, input int cnt);
    @(negedge mclk_in);
    knob_up_in = up;
    knob_dn_in = !up;
    repeat (cnt) @(negedge mclk_in);
    knob_up_in = 1'b0;
    knob_dn_in = 1'b0;
    repeat (4) @(negedge mclk_in);
  endtask : knob

  task automatic wait_freq(input logic [23:0] e);
    for (n = 0; n < 6000 && freq_out !== e; n++) @(negedge mclk_in);
    repeat (2) @(negedge mclk_in);
    chk(freq_out === e && ctl_out === s, "adopted tuning");
  endtask : wait_freq

  task automatic restart();
    @(negedge mclk_in);
    rst_b_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    chk(dig_sel_out === 6'h00 && seg_out === 24'h0 && nrfd_oe_out === 1'b0, "reset outputs");
    chk({nrfd_o_out, ndac_o_out, ndac_oe_out} === 3'b000, "line drive");
    rst_b_in = 1'b1;
    for (n = 0; n < 50 && ready_out !== 1'b1; n++) @(negedge mclk_in);
    chk(ready_out === 1'b1, "restore done");
  endtask : restart

  // Clock, 5 ns period.
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // Monitors sample at the falling edge, where registered outputs have settled.
  always @(negedge mclk_in) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      results();
    end
    for (int k = 0; k < 18; k++)
      if (count_on && dig_sel_out[k % 6] === 1'b1 &&
          seg_out[k / 6 * 8 +: 8] === disp_data_in[k * 8 +: 8])
        on_cnt[k]++;
    if (rst_b_in !== 1'b1) bits = 0;
    else if (syn_clk_out === 1'b1 && clk_prev === 1'b0) begin
      bits++;
      sw = {sw[30:0], syn_data_out};
    end
    clk_prev = syn_clk_out;
    if (syn_load_out === 1'b1) begin
      loads++;
      chk(bits == 32, "serial word length");
      bits = 0;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'hf1708e3f;
    {rst_b_in, intens_en_in, remote_en_in, remote_src_in, key_valid_in} = 5'h0;
    {knob_up_in, knob_dn_in, pwr_fail_in, count_on} = 4'h0;
    {disp_data_in, intens_grp_in, intens_pos_in, key_code_in} = '0;
    jumper_sel_in = 5'($random(seed));
    restart();
    // Display scan: off, bright at the last digit of the last group, random.
    for (int m = 0; m < 3; m++) begin
      @(negedge mclk_in);
      for (int k = 0; k < 18; k++) disp_data_in[k * 8 +: 8] = 8'($random(seed)) | 8'h01;
      intens_en_in = (m != 0);
      intens_grp_in = (m == 1) ? 2'd2 : 2'($unsigned($random(seed)) % 3);
      intens_pos_in = (m == 1) ? 3'd5 : 3'($unsigned($random(seed)) % 6);
      repeat (3) @(posedge mclk_in);
      for (int k = 0; k < 18; k++) on_cnt[k] = 0;
      count_on = 1'b1;
      repeat (8 * SC) @(posedge mclk_in);
      count_on = 1'b0;
      for (int k = 0; k < 18; k++)
        chk(on_cnt[k] == exp_on(k), "on-time");
    end
    // Parallel bus: a foreign select code written last must not reach the latches.
    f = {4'h1, 20'($random(seed))};
    s = 8'($random(seed));
    w = {f, s};
    rc.par_word(jumper_sel_in, w);
    rc.par_word(jumper_sel_in ^ 5'h01, ~w);
    remote_en_in = 1'b1;
    wait_freq(f);
    remote_en_in = 1'b0;
    // IEEE-488: pointer byte under attention, then four data bytes.
    remote_src_in = 1'b1;
    f = {4'h2, 1'b0, 19'($random(seed))};
    s = 8'($random(seed));
    w = {f, s};
    rc.ieee_byte(1'b0, 8'h00);
    for (int i = 0; i < 4; i++) rc.ieee_byte(1'b1, w[31 - 8 * i -: 8]);
    remote_en_in = 1'b1;
    wait_freq(f);
    remote_en_in = 1'b0;
    // Panel: top channel number, store, knob away, recall.
    key(4'h9);
    key(4'h9);
    chk(chan_out === 7'd99, "channel entry");
    key(KEY_STORE);
    n = 1 + $unsigned($random(seed)) % 16;
    knob(1'b1, n);
    knob(1'b0, 3);
    chk(freq_out === f + 24'(n) - 24'd3, "knob tuning");
    key(KEY_RECALL);
    chk(freq_out === f && ctl_out === s, "channel recall");
    key(KEY_STORE);
    // Power loss saves the tuning; the next start brings it back.
    knob(1'b1, 5);
    @(negedge mclk_in);
    pwr_fail_in = 1'b1;
    repeat (20) @(negedge mclk_in);
    pwr_fail_in = 1'b0;
    restart();
    chk(freq_out === f + 24'd5, "restored tuning");
    repeat (400) @(negedge mclk_in);
    chk(loads > 0, "serial words sent");
    chk(sw === {f + 24'd5, s}, "serial word");
    results();
  end
endmodule : tb_top
